// ---- verilog/fds_pkg.sv ----
`default_nettype none
package fds_pkg;

   // Register offsets on the host I/O bus.
   localparam logic [9:0] ADDR_STATUS_A = 10'h3F0;
   localparam logic [9:0] ADDR_STATUS_B = 10'h3F1;
   localparam logic [9:0] ADDR_DRV_OUT  = 10'h3F2;
   localparam logic [9:0] ADDR_DIG_IN   = 10'h3F7;

   // Field positions in the drive output register.
   localparam int DOR_SEL_LSB  = 0;
   localparam int DOR_RST_N    = 2;
   localparam int DOR_DMA_GATE = 3;
   localparam int DOR_MOT0     = 4;
   localparam int DOR_MOT1     = 5;

   // Reset values.
   localparam logic [7:0] DOR_RESET   = 8'h00;
   localparam logic [1:0] DSEL_N_IDLE = 2'h3;

   // Soft reset minimum hold, in ns, and clock rate in MHz.
   localparam int SOFT_RST_NS = 100;
   localparam int CLK_MHZ     = 200;
   localparam int SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;

   // Operating modes of the status registers.
   typedef enum logic [1:0] {
      MODE_BASIC,
      MODE_EXTENDED,
      MODE_ALTERNATE
   } fds_mode_t;

   // Drive-side input pins, true levels.
   typedef struct packed {
      logic indexPulseInput;
      logic trackZeroInput;
      logic writeProtect;
      logic readData;
   } fds_drive_in_t;

   // Levels coming from the controller core on this clock.
   typedef struct packed {
      logic dirInward;
      logic headSideSelect;
      logic stepOut;
      logic writeGateOut;
      logic writeData;
      logic coreIrq;
      logic coreDrq;
   } fds_core_in_t;

   // Host bus pins as sampled.
   typedef struct packed {
      logic [9:0] addr;
      logic [7:0] data;
      logic       readN;
      logic       writeN;
   } fds_host_in_t;

endpackage
`default_nettype wire

// ---- verilog/fds_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module fds_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // Asynchronous input and its synchronised copy.
   input  wire logic [W-1:0] asyncIn,
   output var  logic [W-1:0] syncOut
);

   logic [W-1:0] meta_q;

   // Two-stage synchroniser; the first stage feeds only the second.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q  <= RST_VAL;
         syncOut <= RST_VAL;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/fds_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Extended A: direction, index, track, step, irq.
// - Extended A: true head side, inverted protect.
// - Extended A bit 6 always one.
// - Alternate A: inverted/true pin levels, DMA request.
// - Alternate A step latch, cleared by reads/resets.
// - Basic mode status reads leave bus undriven.
// - Extended B: motor mirrors, live write gate.
// - Extended B toggles on read/write data edges.
// - Extended B bit 5 mirrors drive select 0.
// - Extended B bits 6, 7 read one.
// - Alternate B: select levels, unsupported bits one.
// - Alternate B write gate latch, read clears.
// - Alternate B data latches, ungated by gate.
// - Drive output register: any-time write, zero reset.
// - Binary drive number, one select active.
// - Bit 2 zero holds controller in reset.
// - Soft reset held at least 100 ns.
// - Basic/alternate: bit 3 gates DMA and interrupt.
// - Extended: DMA and interrupt always enabled.
// - Bits 4, 5 drive motor outputs.
// - Status A read-only; writes ignored.
module fds_regs (
   // Clock and reset.
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   // Static mode selection.
   input  wire fds_pkg::fds_mode_t     modeSel,
   // Host bus pins.
   input  wire fds_pkg::fds_host_in_t  hostPins,
   output var  logic [7:0]             hostDataOut,
   output var  logic                   hostDataOe,
   // Drive pins and controller core levels.
   input  wire fds_pkg::fds_drive_in_t drivePins,
   input  wire fds_pkg::fds_core_in_t  coreIn,
   // Drive-side and system outputs.
   output var  logic [1:0]             driveSelectOutN,
   output var  logic [1:0]             motorOut,
   output var  logic                   softResetN,
   output var  logic                   floppyIrqOut,
   output var  logic                   dmaReqOut,
   output var  logic                   dmaReqOe,
   output var  logic                   ackTcEnable
);

   fds_pkg::fds_host_in_t  host;
   fds_pkg::fds_drive_in_t drv;

   // Pins from outside the clock domain are synchronised first.
   fds_sync #(.W(22), .RST_VAL(22'h000003)) uHostSync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .asyncIn (hostPins),
      .syncOut (host)
   );

   fds_sync #(.W(4), .RST_VAL(4'h0)) uDriveSync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .asyncIn (drivePins),
      .syncOut (drv)
   );

   // Address compare shared by read and write decode.
   function automatic logic hit(input logic [9:0] a, input logic [9:0] ref_a);
      hit = (a == ref_a);
   endfunction

   // Control state.
   logic [7:0] dor_q, dor_d;
   logic [4:0] rstCnt_q, rstCnt_d;
   logic       softResetN_d;
   logic       rdPrev_q, wrPrev_q;
   logic [1:0] dselN_d, motor_d;
   logic       irq_d, drq_d, drqOe_d, ackEn_d;
   logic       rdStart, wrEnd, dirRead, swReset, gateOn;

   localparam logic [4:0] RST_CYC = 5'(fds_pkg::SOFT_RST_CYC);

   assign rdStart = rdPrev_q && !host.readN;
   assign wrEnd   = !wrPrev_q && host.writeN;
   assign dirRead = rdStart && hit(host.addr, fds_pkg::ADDR_DIG_IN);
   assign swReset = !softResetN;

   // Register writes, soft reset stretching and output decode.
   always_comb begin
      dor_d = dor_q;
      // Only the drive output register takes writes; status A ignores them.
      if (wrEnd && hit(host.addr, fds_pkg::ADDR_DRV_OUT)) begin
         dor_d = host.data;
      end
      // Reset bit low reloads the hold count, so toggling still lasts.
      rstCnt_d = rstCnt_q;
      if (!dor_d[fds_pkg::DOR_RST_N]) begin
         rstCnt_d = RST_CYC;
      end else if (rstCnt_q != 5'h00) begin
         rstCnt_d = rstCnt_q - 5'h01;
      end
      softResetN_d = dor_d[fds_pkg::DOR_RST_N] && (rstCnt_d == 5'h00);
      // Binary drive number selects one drive when its motor is on.
      dselN_d = fds_pkg::DSEL_N_IDLE;
      if (dor_d[1:0] == 2'h0 && dor_d[fds_pkg::DOR_MOT0]) begin
         dselN_d = 2'h2;
      end else if (dor_d[1:0] == 2'h1 && dor_d[fds_pkg::DOR_MOT1]) begin
         dselN_d = 2'h1;
      end
      motor_d = {dor_d[fds_pkg::DOR_MOT1], dor_d[fds_pkg::DOR_MOT0]};
      // Extended mode keeps the DMA and interrupt pins always on.
      gateOn  = (modeSel == fds_pkg::MODE_EXTENDED)
                || dor_d[fds_pkg::DOR_DMA_GATE];
      irq_d   = gateOn && coreIn.coreIrq;
      drq_d   = gateOn && coreIn.coreDrq;
      drqOe_d = gateOn;
      ackEn_d = gateOn;
   end

   // Control registers.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dor_q           <= fds_pkg::DOR_RESET;
         rstCnt_q        <= 5'h00;
         softResetN      <= 1'b0;
         rdPrev_q        <= 1'b1;
         wrPrev_q        <= 1'b1;
         driveSelectOutN <= fds_pkg::DSEL_N_IDLE;
         motorOut        <= 2'h0;
         floppyIrqOut    <= 1'b0;
         dmaReqOut       <= 1'b0;
         dmaReqOe        <= 1'b0;
         ackTcEnable     <= 1'b0;
      end else begin
         dor_q           <= dor_d;
         rstCnt_q        <= rstCnt_d;
         softResetN      <= softResetN_d;
         rdPrev_q        <= host.readN;
         wrPrev_q        <= host.writeN;
         driveSelectOutN <= dselN_d;
         motorOut        <= motor_d;
         floppyIrqOut    <= irq_d;
         dmaReqOut       <= drq_d;
         dmaReqOe        <= drqOe_d;
         ackTcEnable     <= ackEn_d;
      end
   end

   // Status state: edge history, toggles and latches.
   logic stepPrev_q, wgPrev_q, wdPrev_q, rdataPrev_q;
   logic rdTgl_q, rdTgl_d, wdTgl_q, wdTgl_d;
   logic stepLat_q, stepLat_d, wgLat_q, wgLat_d;
   logic rdLat_q, rdLat_d, wdLat_q, wdLat_d;
   logic [7:0] statA, statB, rdVal, dataOut_d;
   logic       dataOe_d, rdFall, wdFall;

   assign rdFall = rdataPrev_q && !drv.readData;
   assign wdFall = wdPrev_q && !coreIn.writeData;

   // Toggles, latches and the host read mux.
   always_comb begin
      // Toggle bits flip on every inactive-going data edge.
      rdTgl_d = rdTgl_q ^ rdFall;
      wdTgl_d = wdTgl_q ^ wdFall;
      // Latches clear on a digital input read; a new edge wins.
      stepLat_d = stepLat_q;
      if (dirRead || swReset) begin
         stepLat_d = 1'b0;
      end
      if (!stepPrev_q && coreIn.stepOut) begin
         stepLat_d = 1'b1;
      end
      wgLat_d = (wgLat_q && !dirRead)
                || (!wgPrev_q && coreIn.writeGateOut);
      rdLat_d = (rdLat_q && !dirRead) || rdFall;
      wdLat_d = (wdLat_q && !dirRead) || wdFall;
      // Layouts of the two status registers by mode.
      if (modeSel == fds_pkg::MODE_ALTERNATE) begin
         statA = {floppyIrqOut, dmaReqOut, stepLat_q,
                  drv.trackZeroInput, !coreIn.headSideSelect,
                  drv.indexPulseInput, drv.writeProtect, !coreIn.dirInward};
         statB = {1'b1, driveSelectOutN[1], driveSelectOutN[0],
                  wdLat_q, rdLat_q, wgLat_q, 2'h3};
      end else begin
         statA = {floppyIrqOut, 1'b1, coreIn.stepOut,
                  !drv.trackZeroInput, coreIn.headSideSelect,
                  !drv.indexPulseInput, !drv.writeProtect, coreIn.dirInward};
         statB = {2'h3, dor_q[fds_pkg::DOR_SEL_LSB],
                  wdTgl_q, rdTgl_q, coreIn.writeGateOut, motorOut};
      end
      // Read decode; basic mode leaves status reads undriven.
      rdVal    = 8'h00;
      dataOe_d = 1'b0;
      if (!host.readN) begin
         if (hit(host.addr, fds_pkg::ADDR_DRV_OUT)) begin
            rdVal    = dor_q;
            dataOe_d = 1'b1;
         end else if (modeSel != fds_pkg::MODE_BASIC) begin
            if (hit(host.addr, fds_pkg::ADDR_STATUS_A)) begin
               rdVal    = statA;
               dataOe_d = 1'b1;
            end else if (hit(host.addr, fds_pkg::ADDR_STATUS_B)) begin
               rdVal    = statB;
               dataOe_d = 1'b1;
            end
         end
      end
      // Hold the last value while the read strobe stays low.
      dataOut_d = rdStart ? rdVal : hostDataOut;
      if (host.readN) begin
         dataOut_d = 8'h00;
      end
   end

   // Status registers and bus drivers.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stepPrev_q  <= 1'b0;
         wgPrev_q    <= 1'b0;
         wdPrev_q    <= 1'b0;
         rdataPrev_q <= 1'b0;
         rdTgl_q     <= 1'b0;
         wdTgl_q     <= 1'b0;
         stepLat_q   <= 1'b0;
         wgLat_q     <= 1'b0;
         rdLat_q     <= 1'b0;
         wdLat_q     <= 1'b0;
         hostDataOut <= 8'h00;
         hostDataOe  <= 1'b0;
      end else begin
         stepPrev_q  <= coreIn.stepOut;
         wgPrev_q    <= coreIn.writeGateOut;
         wdPrev_q    <= coreIn.writeData;
         rdataPrev_q <= drv.readData;
         rdTgl_q     <= rdTgl_d;
         wdTgl_q     <= wdTgl_d;
         stepLat_q   <= stepLat_d;
         wgLat_q     <= wgLat_d;
         rdLat_q     <= rdLat_d;
         wdLat_q     <= wdLat_d;
         hostDataOut <= dataOut_d;
         hostDataOe  <= dataOe_d;
      end
   end

endmodule
`default_nettype wire

// ---- tb/fds_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module fds_monitor (
   // Clock and reset.
   input wire logic                   ref_clk,
   input wire logic                   nrst,
   // Watched ports.
   input wire fds_pkg::fds_mode_t     modeSel,
   input wire fds_pkg::fds_host_in_t  hostPins,
   input wire logic [7:0]             hostDataOut,
   input wire logic                   hostDataOe,
   input wire fds_pkg::fds_drive_in_t drivePins,
   input wire fds_pkg::fds_core_in_t  coreIn,
   input wire logic [1:0]             driveSelectOutN,
   input wire logic [1:0]             motorOut,
   input wire logic                   softResetN,
   input wire logic                   floppyIrqOut,
   input wire logic                   dmaReqOut,
   input wire logic                   dmaReqOe,
   input wire logic                   ackTcEnable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] lowCnt_q;
   wire logic  ext = (modeSel == fds_pkg::MODE_EXTENDED);
   // Counts the cycles that the soft reset has been held low.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) lowCnt_q <= 8'h00;
      else if (softResetN) lowCnt_q <= 8'h00;
      else if (lowCnt_q != 8'hFF) lowCnt_q <= lowCnt_q + 8'h01;
   end
   // A host read of the drive output register and its answer.
   sequence rdDor_s;
      $fell(hostPins.readN) && hostPins.addr == fds_pkg::ADDR_DRV_OUT;
   endsequence
   sequence oeOn_s;
      ##[3:5] hostDataOe;
   endsequence
   AST_SEL_ONE: assert property (driveSelectOutN != 2'h0)
      else $error("two drive selects active");
   AST_MOTOR: assert property ((motorOut | driveSelectOutN) == 2'h3)
      else $error("drive selected without its motor");
   AST_SOFT_HOLD: assert property ($rose(softResetN) |-> lowCnt_q >= 8'h14)
      else $error("soft reset released too early");
   AST_EXT_EN: assert property (ext && $past(nrst) |-> dmaReqOe && ackTcEnable)
      else $error("extended mode gate closed");
   AST_EXT_IRQ: assert property (ext && $past(nrst) |-> floppyIrqOut == $past(coreIn.coreIrq))
      else $error("interrupt does not follow core");
   AST_GATE_TIE: assert property (!ext |-> dmaReqOe == ackTcEnable)
      else $error("gated enables disagree");
   AST_BASIC_Z: assert property (modeSel == fds_pkg::MODE_BASIC && hostPins.addr[9:1] == 9'h1F8
      |-> !hostDataOe)
      else $error("status read drove the bus");
   AST_RD_OE: assert property (rdDor_s |-> oeOn_s)
      else $error("register read not answered");
endmodule
bind fds_regs fds_monitor fds_monitor_i (.*);
`default_nettype wire

// ---- tb/fds_drive_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fds_drive_model (
   // Clock and reset.
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   // Pin levels and a read pulse request.
   input  wire fds_pkg::fds_drive_in_t lvl,
   input  wire logic                   rdPulse,
   // Pins toward the controller.
   output var  fds_pkg::fds_drive_in_t drivePins
);
   logic [2:0] cnt_q;
   // Each request gives one read-data pulse of three cycles.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) cnt_q <= 3'h0;
      else if (rdPulse) cnt_q <= 3'h3;
      else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
   end
   // The read line idles low between flux pulses.
   always_comb begin
      drivePins = lvl;
      drivePins.readData = (cnt_q != 3'h0);
   end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                   ref_clk, nrst, rdPulse, hostDataOe, softResetN;
   logic                   floppyIrqOut, dmaReqOut, dmaReqOe, ackTcEnable;
   logic [1:0]             driveSelectOutN, motorOut;
   logic [7:0]             hostDataOut;
   fds_pkg::fds_mode_t     modeSel;
   fds_pkg::fds_host_in_t  hostPins;
   fds_pkg::fds_drive_in_t lvl, drivePins;
   fds_pkg::fds_core_in_t  coreIn;
   int                     miscompares, n_compared, cycles;
   wire logic [7:0] outs = {softResetN, floppyIrqOut, dmaReqOe, ackTcEnable,
                            driveSelectOutN, motorOut};
   fds_regs fds_regs_i (.*);
   fds_drive_model fds_drive_model_i (.*);
   // Clock at 200 MHz.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      #1;
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hw(input fds_pkg::fds_mode_t m);
      @(posedge ref_clk);
      nrst <= 1'b0;
      modeSel <= m;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      hostPins.addr <= a;
      hostPins.data <= d;
      hostPins.writeN <= 1'b0;
      repeat (3) @(posedge ref_clk);
      hostPins.writeN <= 1'b1;
      repeat (4) @(posedge ref_clk);
      hostPins.data <= ~d;
      repeat (2) @(posedge ref_clk);
   endtask
   // Kind 0 expects no drive, 1 expects data, 2 checks nothing.
   task automatic rdb(input logic [9:0] a, input logic [7:0] e, input int k);
      @(posedge ref_clk);
      hostPins.addr <= a;
      hostPins.readN <= 1'b0;
      repeat (7) @(posedge ref_clk);
      if (k < 2) chk({7'h00, hostDataOe}, {7'h00, k[0]});
      if (k == 1) chk(hostDataOut, e);
      @(posedge ref_clk);
      hostPins.readN <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic t_drive();
      hw(fds_pkg::MODE_EXTENDED);
      rdb(10'h3F2, 8'h00, 1);
      chk(outs, 8'h3C);
      wr(10'h3F2, 8'h1C);
      chk(outs, 8'h39);
      repeat (20) @(posedge ref_clk);
      chk(outs, 8'hB9);
      wr(10'h3F2, 8'h2D);
      chk(outs, 8'hB6);
      wr(10'h3F2, 8'h29);
      chk(outs, 8'h36);
      wr(10'h3F2, 8'h2D);
      repeat (20) @(posedge ref_clk);
      chk(outs, 8'hB6);
      wr(10'h3F0, 8'hFF);
      rdb(10'h3F2, 8'h2D, 1);
   endtask
   task automatic t_ext();
      lvl <= 4'hA;
      coreIn <= 7'h69;
      repeat (4) @(posedge ref_clk);
      rdb(10'h3F0, 8'h59, 1);
      rdb(10'h3F1, 8'hE6, 1);
      rdPulse <= 1'b1;
      coreIn <= 7'h6D;
      @(posedge ref_clk);
      rdPulse <= 1'b0;
      coreIn <= 7'h6B;
      repeat (8) @(posedge ref_clk);
      rdb(10'h3F0, 8'hD9, 1);
      rdb(10'h3F1, 8'hFE, 1);
      chk({7'h00, dmaReqOut}, 8'h01);
   endtask
   task automatic t_alt();
      coreIn <= 7'h61;
      hw(fds_pkg::MODE_ALTERNATE);
      wr(10'h3F2, 8'h2D);
      repeat (20) @(posedge ref_clk);
      rdPulse <= 1'b1;
      coreIn <= 7'h7D;
      @(posedge ref_clk);
      rdPulse <= 1'b0;
      coreIn <= 7'h6B;
      repeat (8) @(posedge ref_clk);
      chk(outs, 8'hF6);
      rdb(10'h3F0, 8'hE6, 1);
      rdb(10'h3F1, 8'hBF, 1);
      rdb(10'h3F7, 8'h00, 2);
      rdb(10'h3F0, 8'hC6, 1);
      rdb(10'h3F1, 8'hA3, 1);
      wr(10'h3F2, 8'h25);
      chk(outs, 8'h86);
      chk({7'h00, dmaReqOut}, 8'h00);
   endtask
   task automatic t_basic();
      hw(fds_pkg::MODE_BASIC);
      rdb(10'h3F0, 8'h00, 0);
      rdb(10'h3F1, 8'h00, 0);
      wr(10'h3F2, 8'h0C);
      chk(outs, 8'h7C);
      rdb(10'h3F2, 8'h0C, 1);
   endtask
   // Main sequence.
   initial begin
      nrst = 1'b0;
      modeSel = fds_pkg::MODE_EXTENDED;
      hostPins = {10'h000, 8'h00, 2'h3};
      lvl = 4'h0;
      coreIn = 7'h00;
      rdPulse = 1'b0;
      t_drive();
      t_ext();
      t_alt();
      t_basic();
      close_out();
   end
endmodule
`default_nettype wire
